// File: verilog/adc_status_flag_reporting.v
// status word flags and codes for the delta-sigma converter core
//
// Notes on behaviour
// - a system gain calibration that overranges sets the gain overrange flag and pins the coefficient at its largest value.
// - a result beyond the largest or smallest code is clipped to it and flags clipping, and an in-range result clears that flag.
// - the analog overrange flag is set when the modulator sees the gain-scaled input beyond the reference.
// - the four-bit rate tag reports the rate of the result now held, or of the last coefficient calculation.
// - the power phase code reads 00 converting, 01 sleep, 10 standby, 11 reset, and standby after reset.
// - the modulator busy flag is high during conversion, self calibration or system calibration and low otherwise.
// - in sequencer mode 1 a new result sets the result ready flag.
// - a complete read of the matching data register clears the result ready flag and a partial read leaves it.
// - the active-low ready pin always shows the same indication as the result ready flag.
`include "adc_status_regs.vh"

module adc_status_flag_reporting #(
   parameter RAW_W  = 26,                        // raw filter output width
   parameter DATA_W = 24,                        // reported result width
   parameter RATE_W = 4                          // conversion rate tag width
) (
   input  wire                        ref_clk_in,           // core clock, 250 MHz
   input  wire                        rst_b_in,             // async reset, active low
   // conversion results
   input  wire                        conv_valid_in,        // raw result strobe
   input  wire [RAW_W-1:0]            conv_raw_in,          // raw signed result
   input  wire [RATE_W-1:0]           conv_rate_in,         // rate of this result
   input  wire                        analog_over_in,       // modulator input beyond ref
   // calibration
   input  wire                        cal_coef_done_in,     // coefficient calc finished
   input  wire [RATE_W-1:0]           cal_rate_in,          // rate used for the calc
   input  wire                        gain_cal_done_in,     // system gain cal finished
   input  wire                        gain_cal_over_in,     // gain cal came out overrange
   input  wire [DATA_W-1:0]           gain_cal_coef_in,     // computed gain coefficient
   // activity and power
   input  wire                        conv_active_in,       // conversion in progress
   input  wire                        self_cal_active_in,   // self calibration running
   input  wire                        sys_cal_active_in,    // system calibration running
   input  wire                        in_reset_in,          // core held in reset state
   input  wire                        sleep_in,             // core asleep
   input  wire                        converting_in,        // core in conversion state
   // sequencer and host access
   input  wire [1:0]                  seq_mode_in,          // active sequencer mode
   input  wire                        data_read_full_in,    // data register fully read
   input  wire                        status_wr_in,         // host write aimed at status
   input  wire [`UPPER_FIELD_W-1:0]   upper_status_in,      // flags kept by other blocks
   // outputs
   output wire [`COND_WORD_W-1:0]     adc_condition_word_out, // status word as read
   output reg  [DATA_W-1:0]           result_data_out,      // clipped conversion result
   output reg  [DATA_W-1:0]           gain_coef_out,        // gain coefficient in use
   output wire                        result_ready_pin_n_out // ready pin, active low
);

   // flag and code registers; every bit of the lower word is a flop so a
   // read that straddles an update still sees one coherent set of values
   reg                gain_cal_overrange_flag_ff;
   reg                digital_clip_flag_ff;
   reg                analog_overrange_flag_ff;
   reg                analog_seen_ff;
   reg [RATE_W-1:0]   rate_tag_ff;
   reg [1:0]          power_phase_code_ff;
   reg                modulator_busy_flag_ff;
   reg                result_ready_flag_ff;

   // next values
   reg [1:0]          nxt_power_phase_code;
   reg                nxt_result_ready_flag;
   reg [RATE_W-1:0]   nxt_rate_tag;

   // clipper outputs
   wire               clip_valid;
   wire [DATA_W-1:0]  clip_data;
   wire [RATE_W-1:0]  clip_rate;
   wire               clip_hit;

   // host writes are not a source of state: the word is built only from
   // converter events, so the write strobe deliberately reaches no register;
   // a write path here would let the host fake a clean status
   wire               host_write_ignored = status_wr_in;

   // saturate raw results; rate tag rides along so it matches its result
   // the clipper adds one cycle, so results reach the word two edges on
   result_clipper #(
      .RAW_W (RAW_W),
      .OUT_W (DATA_W),
      .TAG_W (RATE_W)
   ) u_clipper (
      .ref_clk_in     (ref_clk_in),
      .rst_b_in       (rst_b_in),
      .raw_valid_in   (conv_valid_in),
      .raw_data_in    (conv_raw_in),
      .raw_tag_in     (conv_rate_in),
      .clip_valid_out (clip_valid),
      .clip_data_out  (clip_data),
      .clip_tag_out   (clip_rate),
      .clip_hit_out   (clip_hit)
   );

   // result register and digital clip flag update together with each result
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         result_data_out      <= `RST_DATA;
         digital_clip_flag_ff <= `RST_FLAG;
      end else if (clip_valid) begin
         result_data_out      <= clip_data;
         digital_clip_flag_ff <= clip_hit;
      end
   end

   // analog overrange is remembered across the conversion so a short
   // excursion between results is not lost, then reported with the result;
   // a level that stays high across a result keeps the flag set
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         analog_seen_ff           <= `RST_FLAG;
         analog_overrange_flag_ff <= `RST_FLAG;
      end else if (clip_valid) begin
         analog_overrange_flag_ff <= analog_seen_ff | analog_over_in;
         analog_seen_ff           <= analog_over_in;
      end else if (analog_over_in) begin
         analog_seen_ff           <= 1'b1;
         analog_overrange_flag_ff <= 1'b1;
      end
   end

   // system gain calibration outcome; overrange pins the coefficient at max
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         gain_cal_overrange_flag_ff <= `RST_FLAG;
         gain_coef_out              <= `RST_DATA;
      end else if (gain_cal_done_in) begin
         gain_cal_overrange_flag_ff <= gain_cal_over_in;
         if (gain_cal_over_in) begin
            gain_coef_out <= `GAIN_COEF_MAX;
         end else begin
            gain_coef_out <= gain_cal_coef_in;
         end
      end
   end

   // rate tag follows whichever of result or coefficient came last; a
   // result landing with a calibration finish wins since it fills the data
   always @* begin
      nxt_rate_tag = rate_tag_ff;
      if (clip_valid) begin
         nxt_rate_tag = clip_rate;
      end else if (cal_coef_done_in) begin
         nxt_rate_tag = cal_rate_in;
      end
   end

   // no invalidation on data read: the host may not rely on it afterwards
   // a data read is not an input here, so a stale tag simply stays visible
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rate_tag_ff <= `RST_RATE;
      end else begin
         rate_tag_ff <= nxt_rate_tag;
      end
   end

   // power phase encoding; reset outranks sleep which outranks conversion
   always @* begin
      if (in_reset_in) begin
         nxt_power_phase_code = `PHASE_RESET;
      end else if (sleep_in) begin
         nxt_power_phase_code = `PHASE_SLEEP;
      end else if (converting_in) begin
         nxt_power_phase_code = `PHASE_CONVERSION;
      end else begin
         nxt_power_phase_code = `PHASE_STANDBY;
      end
   end

   // phase and busy registered; costs one cycle of lag but keeps the word steady
   // standby is also the code held while the async reset is low
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         power_phase_code_ff    <= `RST_PHASE;
         modulator_busy_flag_ff <= `RST_FLAG;
      end else begin
         power_phase_code_ff    <= nxt_power_phase_code;
         modulator_busy_flag_ff <= conv_active_in | self_cal_active_in
                                   | sys_cal_active_in;
      end
   end

   // result ready: set by a new result in single mode, cleared only by a
   // complete read; a new result in the same cycle as the read keeps it set
   // partial reads never reach this block, so they cannot clear the flag
   always @* begin
      nxt_result_ready_flag = result_ready_flag_ff;
      if (data_read_full_in) begin
         nxt_result_ready_flag = 1'b0;
      end
      if (clip_valid && (seq_mode_in == `SEQ_MODE_SINGLE)) begin
         nxt_result_ready_flag = 1'b1;
      end
   end

   // in modes 0, 2 and 3 the flag is left untouched by results and is meaningless
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         result_ready_flag_ff <= `RST_FLAG;
      end else begin
         result_ready_flag_ff <= nxt_result_ready_flag;
      end
   end

   // pin driven from the same flop as the flag so the two cannot disagree
   assign result_ready_pin_n_out = ~result_ready_flag_ff;

   // status word assembly; the upper fields belong to neighbouring logic
   // and pass straight through without adding any latency
   assign adc_condition_word_out = {
      upper_status_in,
      gain_cal_overrange_flag_ff,
      digital_clip_flag_ff,
      analog_overrange_flag_ff,
      rate_tag_ff,
      power_phase_code_ff,
      modulator_busy_flag_ff,
      result_ready_flag_ff
   };

endmodule // adc_status_flag_reporting

// File: pkg/adc_status_regs.vh
// status word layout, codes and reset values for the converter status reporting block
`ifndef ADC_STATUS_REGS_VH
`define ADC_STATUS_REGS_VH

// word geometry
`define COND_WORD_W          24
`define UPPER_FIELD_W        13
`define UPPER_FIELD_LSB      11

// field positions inside adc_condition_word
`define POS_GAIN_CAL_OVR     10
`define POS_DIGITAL_CLIP     9
`define POS_ANALOG_OVR       8
`define POS_RATE_MSB         7
`define POS_RATE_LSB         4
`define POS_PHASE_MSB        3
`define POS_PHASE_LSB        2
`define POS_MOD_BUSY         1
`define POS_RESULT_READY     0

// power phase codes
`define PHASE_CONVERSION     2'h0
`define PHASE_SLEEP          2'h1
`define PHASE_STANDBY        2'h2
`define PHASE_RESET          2'h3

// sequencer mode in which the single result ready flag is meaningful
`define SEQ_MODE_SINGLE      2'h1

// reset values
`define RST_PHASE            `PHASE_STANDBY
`define RST_RATE             4'h0
`define RST_FLAG             1'b0
`define RST_DATA             24'h000000

// largest gain coefficient, unsigned 1.23 format, just under 2.0
`define GAIN_COEF_MAX        24'hFFFFFF

`endif

// File: verilog/result_clipper.v
// saturating stage for raw conversion results, carrying a tag alongside the result
module result_clipper #(
   parameter RAW_W = 26,                         // width of the raw filter output
   parameter OUT_W = 24,                         // width of the reported result
   parameter TAG_W = 4                           // width of the sideband tag
) (
   input  wire                 ref_clk_in,       // core clock
   input  wire                 rst_b_in,         // async reset, active low
   input  wire                 raw_valid_in,     // raw result strobe
   input  wire [RAW_W-1:0]     raw_data_in,      // raw signed result
   input  wire [TAG_W-1:0]     raw_tag_in,       // tag travelling with the result
   output reg                  clip_valid_out,   // clipped result strobe
   output reg  [OUT_W-1:0]     clip_data_out,    // clipped signed result
   output reg  [TAG_W-1:0]     clip_tag_out,     // tag of the clipped result
   output reg                  clip_hit_out      // result was limited
);

   // signed limits of the reported code, built at raw width
   wire signed [RAW_W-1:0] max_code = {{(RAW_W-OUT_W+1){1'b0}}, {(OUT_W-1){1'b1}}};
   wire signed [RAW_W-1:0] min_code = {{(RAW_W-OUT_W+1){1'b1}}, {(OUT_W-1){1'b0}}};
   wire signed [RAW_W-1:0] raw_s    = raw_data_in;
   wire                    over_hi  = (raw_s > max_code);
   wire                    over_lo  = (raw_s < min_code);

   // register the limited result so the data bus never sees a glitching code
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         clip_valid_out <= 1'b0;
         clip_data_out  <= {OUT_W{1'b0}};
         clip_tag_out   <= {TAG_W{1'b0}};
         clip_hit_out   <= 1'b0;
      end else begin
         clip_valid_out <= raw_valid_in;
         if (raw_valid_in) begin
            clip_tag_out <= raw_tag_in;
            clip_hit_out <= over_hi | over_lo;
            if (over_hi) begin
               clip_data_out <= max_code[OUT_W-1:0];
            end else if (over_lo) begin
               clip_data_out <= min_code[OUT_W-1:0];
            end else begin
               clip_data_out <= raw_data_in[OUT_W-1:0];
            end
         end
      end
   end

endmodule // result_clipper

// File: verification/adc_status_flag_reporting_checker.sv
// checker of status word, result and ready pin timing
`include "adc_status_regs.vh"
module adc_status_checker #(
   parameter RAW_W  = 26,  // raw width
   parameter DATA_W = 24   // result width
) (
   input wire                    ref_clk_in,             // clock
   input wire                    rst_b_in,               // reset, active low
   input wire                    conv_valid_in,          // result strobe
   input wire [RAW_W-1:0]        conv_raw_in,            // raw result
   input wire [3:0]              conv_rate_in,           // result rate
   input wire                    analog_over_in,         // modulator overrange
   input wire                    gain_cal_done_in,       // gain cal done
   input wire                    gain_cal_over_in,       // gain cal over
   input wire                    conv_active_in,         // converting
   input wire                    self_cal_active_in,     // self cal
   input wire                    sys_cal_active_in,      // system cal
   input wire [1:0]              seq_mode_in,            // sequencer mode
   input wire                    data_read_full_in,      // full data read
   input wire [`COND_WORD_W-1:0] adc_condition_word_out, // status word
   input wire [DATA_W-1:0]       result_data_out,        // result
   input wire [DATA_W-1:0]       gain_coef_out,          // gain coefficient
   input wire                    result_ready_pin_n_out  // ready pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // helper terms; a raw value beyond 24 signed bits must be limited
   wire              out_rng  = $signed(conv_raw_in) > 24'sh7FFFFF ||
                                $signed(conv_raw_in) < -25'sh800000;
   wire              busy_src = conv_active_in | self_cal_active_in | sys_cal_active_in;
   wire              raw_neg  = conv_raw_in[RAW_W-1];
   wire [DATA_W-1:0] raw_low  = conv_raw_in[DATA_W-1:0];
   wire [23:0]       w        = adc_condition_word_out;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_clipped; conv_valid_in && out_rng; endsequence
   sequence s_single; conv_valid_in ##1 seq_mode_in == `SEQ_MODE_SINGLE; endsequence
   chk_clip_limit: assert property (s_clipped |-> ##2 w[9] &&
      result_data_out == ($past(raw_neg, 2) ? 24'h800000 : 24'h7FFFFF)) else $error("bad clip");
   chk_clip_pass: assert property (conv_valid_in && !out_rng |-> ##2 !w[9] &&
      result_data_out == $past(raw_low, 2)) else $error("bad in-range result");
   chk_rate_tag: assert property (conv_valid_in |-> ##2 w[7:4] == $past(conv_rate_in, 2))
      else $error("bad rate tag");
   chk_gain_max: assert property (gain_cal_done_in && gain_cal_over_in |=> w[10] &&
      gain_coef_out == `GAIN_COEF_MAX) else $error("bad gain overrange");
   chk_busy_tracks: assert property (1'b1 |=> w[1] == $past(busy_src))
      else $error("bad busy flag");
   chk_ready_set: assert property (s_single |=> w[0])
      else $error("ready not set");
   chk_ready_clear: assert property (data_read_full_in &&
      !($past(conv_valid_in) && seq_mode_in == `SEQ_MODE_SINGLE) |=> !w[0])
      else $error("ready not cleared");
   chk_pin_agrees: assert property (result_ready_pin_n_out == !w[0])
      else $error("pin and flag differ");
   chk_analog_set: assert property (analog_over_in |=> w[8])
      else $error("analog overrange not set");
endmodule // adc_status_checker
bind adc_status_flag_reporting adc_status_checker #(.RAW_W(RAW_W), .DATA_W(DATA_W)) u_chk (
   .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .conv_valid_in(conv_valid_in),
   .conv_raw_in(conv_raw_in), .conv_rate_in(conv_rate_in), .analog_over_in(analog_over_in),
   .gain_cal_done_in(gain_cal_done_in), .gain_cal_over_in(gain_cal_over_in),
   .conv_active_in(conv_active_in), .self_cal_active_in(self_cal_active_in),
   .sys_cal_active_in(sys_cal_active_in), .seq_mode_in(seq_mode_in),
   .data_read_full_in(data_read_full_in), .adc_condition_word_out(adc_condition_word_out),
   .result_data_out(result_data_out), .gain_coef_out(gain_coef_out),
   .result_ready_pin_n_out(result_ready_pin_n_out));

// File: verification/host_status_reader.sv
// host model that reads the status word and the data registers
module host_status_reader (
   input  wire logic        ref_clk_in,         // clock
   input  wire logic        rst_b_in,           // reset, active low
   input  wire logic        read_req_in,        // full data read wanted
   input  wire logic        write_req_in,       // status write wanted
   input  wire logic [1:0]  seq_mode_in,        // sequencer mode
   input  wire logic [23:0] word_in,            // status word
   output logic             data_read_full_out, // full data read done
   output logic             status_wr_out,      // write to status word
   output logic [3:0]       rate_seen_out,      // rate taken before the read
   output logic             ready_seen_out      // ready as trusted
);
   timeunit 1ns;
   timeprecision 1ps;
   // rate is captured ahead of the data read, since it goes stale after
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         {data_read_full_out, status_wr_out, rate_seen_out} <= 6'h00;
      end else begin
         data_read_full_out <= read_req_in;
         status_wr_out <= write_req_in;
         if (read_req_in) rate_seen_out <= word_in[7:4];
      end
   end
   // ready has no meaning outside single mode
   assign ready_seen_out = word_in[0] && seq_mode_in == 2'h1;
endmodule // host_status_reader

// File: verification/tb_adc_status_flag_reporting.sv
// self-checking bench for the status flag reporting block
module tb_adc_status_flag_reporting;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_b, cv, ao, ccd, gcd, gco, ca, sca, sya, ir, sl, cn, rd, wr;
   logic        drf, swr, pin_n, seen;
   logic [25:0] raw;
   logic [3:0]  rate, crate, rseen;
   logic [1:0]  mode, vp;
   logic [12:0] upper;
   logic [23:0] coef, word, data, gcoef, snap;
   logic [31:0] exp_q[$];
   int          fail_count, cmp_count;
   logic [25:0] tbl[6] = '{26'h07FFFFF, 26'h0800000, 26'h3800000, 26'h37FFFFF,
                           26'h0001234, 26'h1FFFFFF};
   adc_status_flag_reporting dut (.ref_clk_in(clk), .rst_b_in(rst_b), .conv_valid_in(cv),
      .conv_raw_in(raw), .conv_rate_in(rate), .analog_over_in(ao), .cal_coef_done_in(ccd),
      .cal_rate_in(crate), .gain_cal_done_in(gcd), .gain_cal_over_in(gco),
      .gain_cal_coef_in(coef), .conv_active_in(ca), .self_cal_active_in(sca),
      .sys_cal_active_in(sya), .in_reset_in(ir), .sleep_in(sl), .converting_in(cn),
      .seq_mode_in(mode), .data_read_full_in(drf), .status_wr_in(swr),
      .upper_status_in(upper), .adc_condition_word_out(word), .result_data_out(data),
      .gain_coef_out(gcoef), .result_ready_pin_n_out(pin_n));
   host_status_reader host (.ref_clk_in(clk), .rst_b_in(rst_b), .read_req_in(rd),
      .write_req_in(wr), .seq_mode_in(mode), .word_in(word), .data_read_full_out(drf),
      .status_wr_out(swr), .rate_seen_out(rseen), .ready_seen_out(seen));
   // clock at 4 ns
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      check(exp_q.size(), 32'h0);
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // one result strobe; the expected clip and flag are noted first
   task automatic conv(input logic [25:0] r, input logic [3:0] t);
      logic hi, lo;
      hi = $signed(r) > 24'sh7FFFFF;
      lo = $signed(r) < -25'sh800000;
      exp_q.push_back({3'h0, hi | lo, t, hi ? 24'h7FFFFF : lo ? 24'h800000 : r[23:0]});
      @(posedge clk);
      {cv, raw, rate} <= {1'b1, r, t};
   endtask
   // drop every pulse, then let n edges pass and settle
   task automatic tick(input int n);
      @(posedge clk);
      {cv, rd, wr, ccd, gcd, ao} <= 6'h00;
      repeat (n - 1) @(posedge clk);
      #1;
   endtask
   // results land two edges after their strobe
   always @(posedge clk) begin
      vp <= {vp[0], cv};
      if (vp[0]) begin
         #1;
         check({3'h0, word[9], word[7:4], data}, exp_q.pop_front());
      end
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      end_sim();
   end
   initial begin
      {cv, ao, ccd, gcd, gco, ca, sca, sya, ir, sl, cn, rd, wr, rst_b} = 14'h0000;
      {raw, rate, crate, coef, upper, vp} = 73'h0;
      {mode, fail_count, cmp_count} = {2'h1, 32'h0, 32'h0};
      void'($urandom(32'h3231));
      repeat (2) @(posedge clk);
      #1;
      check({pin_n, word[10:0]}, 32'h808);
      @(posedge clk);
      rst_b <= 1'b1;
      // limits, their neighbours and random results, back to back
      foreach (tbl[i]) conv(tbl[i], 4'(i));
      repeat (6) conv(26'($urandom), 4'($urandom));
      tick(3);
      $display("clip test done");
      check({pin_n, word[0], seen}, 32'h3);
      @(posedge clk);
      rd <= 1'b1;
      tick(3);
      check({pin_n, word[0], rseen}, {26'h0, 2'h2, rate});
      $display("ready test done");
      // results in the other modes must leave ready clear
      for (int m = 0; m < 4; m++) begin
         if (m != 1) begin
            @(posedge clk);
            mode <= 2'(m);
            conv(26'($urandom), 4'(m));
            tick(3);
            check({word[0], seen}, 32'h0);
         end
      end
      $display("mode test done");
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         {gcd, gco, coef} <= {1'b1, k[0], 24'($urandom)};
         tick(1);
         check({word[10], gcoef}, {7'h0, k[0], k[0] ? 24'hFFFFFF : coef});
      end
      @(posedge clk);
      ao <= 1'b1;
      tick(1);
      check(word[8], 32'h1);
      repeat (16) begin
         @(posedge clk);
         {ir, sl, cn, ca, sca, sya} <= 6'($urandom);
         tick(1);
         check(word[3:1], {ir ? 2'h3 : sl ? 2'h1 : cn ? 2'h0 : 2'h2, ca | sca | sya});
      end
      @(posedge clk);
      {ir, sl, cn, ccd, crate, upper} <= {4'h1, 4'hA, 13'($urandom)};
      tick(1);
      check({word[23:11], word[7:4]}, {upper, 4'hA});
      snap = word;
      @(posedge clk);
      wr <= 1'b1;
      tick(3);
      check(word, snap);
      $display("flag test done");
      end_sim();
   end
endmodule // tb_adc_status_flag_reporting
